// ===== verilog/adc_ctrl_pkg.sv
package adc_ctrl_pkg;

  // ==========================================================
  // register map
  localparam logic [11:0] OFS_PIN_CFG_LOW  = 12'hF48;
  localparam logic [11:0] OFS_PIN_CFG_HIGH = 12'hF49;
  localparam logic [11:0] OFS_CONV_CONFIG  = 12'hFC1;
  localparam logic [11:0] OFS_CONV_CONTROL = 12'hFC2;
  localparam logic [11:0] OFS_RESULT_LOW   = 12'hFC3;
  localparam logic [11:0] OFS_RESULT_HIGH  = 12'hFC4;
  localparam logic [11:0] OFS_STATUS       = 12'hFC5;

  localparam logic [7:0] RST_PIN_CFG  = 8'h00;
  localparam logic [7:0] RST_CONFIG   = 8'h00;
  localparam logic [7:0] RST_CONTROL  = 8'h00;

  // ==========================================================
  // field positions
  localparam int BIT_NEG_REF   = 7;
  localparam int BIT_POS_REF   = 6;
  localparam int BIT_CHS_HI    = 5;
  localparam int BIT_CHS_LO    = 2;
  localparam int BIT_GO        = 1;
  localparam int BIT_ON        = 0;
  localparam int BIT_JUSTIFY   = 7;
  localparam int BIT_CAL       = 6;
  localparam int BIT_ACQ_HI    = 5;
  localparam int BIT_ACQ_LO    = 3;
  localparam int BIT_CLK_HI    = 2;
  localparam int BIT_CLK_LO    = 0;
  localparam int BIT_BG_REQ    = 7;
  localparam int BIT_DONE_FLAG = 0;

  localparam logic [3:0] CHS_LAST_PIN = 4'hC;
  localparam logic [3:0] CHS_RESERVED = 4'hD;
  localparam logic [3:0] CHS_CORE     = 4'hE;
  localparam logic [3:0] CHS_BANDGAP  = 4'hF;
  localparam logic [2:0] CLK_RC       = 3'h3;

  // ==========================================================
  // timing
  localparam int CLK_MHZ         = 200;
  localparam int CYCLE_NS        = 5;
  localparam int INSTR_CYCLE_NS  = 20;
  localparam int INSTR_CYCLES    = (INSTR_CYCLE_NS + CYCLE_NS - 1) / CYCLE_NS;
  localparam int RC_DIV_DEFAULT  = 8;
  localparam int RESULT_BITS     = 10;
  localparam int CONV_TADS       = 11;
  localparam int CAL_EXTRA_TADS  = 12;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_ACQ   = 2'b11,
    ST_CONV  = 2'b10
  } conv_state_e;

endpackage : adc_ctrl_pkg

// ===== verilog/tad_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tad_divider
  import adc_ctrl_pkg::*;
#(
  parameter int RC_DIV = RC_DIV_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       run,
  input  wire logic [2:0] clk_sel,
  output logic            tad_tick
);

  logic [6:0] cnt_r;
  logic [6:0] limit;

  // ==========================================================
  // divide ratio per clock select code
  always_comb begin
    unique case (clk_sel)
      3'h0:    limit = 7'd2;
      3'h1:    limit = 7'd8;
      3'h2:    limit = 7'd32;
      3'h3:    limit = 7'(RC_DIV);
      3'h4:    limit = 7'd4;
      3'h5:    limit = 7'd16;
      default: limit = 7'd64;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r    <= 7'h00;
      tad_tick <= 1'b0;
    end else if (!run) begin
      cnt_r    <= 7'h00;
      tad_tick <= 1'b0;
    end else if (cnt_r >= limit - 7'd1) begin
      cnt_r    <= 7'h00;
      tad_tick <= 1'b1;
    end else begin
      cnt_r    <= cnt_r + 7'd1;
      tad_tick <= 1'b0;
    end
  end

endmodule : tad_divider
`default_nettype wire

// ===== verilog/adc_control_config.sv
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module adc_control_config
  import adc_ctrl_pkg::*;
#(
  parameter int        RC_DIV      = RC_DIV_DEFAULT,
  parameter bit        LARGE_PKG   = 1'b1,
  parameter int        NUM_PINS    = 13
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [11:0]               wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      cmp_done,
  input  wire logic [RESULT_BITS-1:0]    cmp_data,
  input  wire logic                      bg_other_req,
  input  wire logic [NUM_PINS-1:0]       pin_din,
  output logic      [NUM_PINS-1:0]       pin_din_gated,
  output logic      [NUM_PINS-1:0]       pin_analog_en,
  output logic      [3:0]                analog_mux_sel,
  output logic                           neg_ref_ext,
  output logic                           pos_ref_ext,
  output logic                           converter_enable,
  output logic                           sample_en,
  output logic                           conv_start,
  output logic                           conv_calibrate,
  output logic                           conv_bit_clk,
  output logic                           bandgap_power,
  output logic                           conversion_done_flag
);

  conv_state_e state_r;

  logic [7:0]  control_r;
  logic [7:0]  config_r;
  logic [7:0]  pin_cfg_low_r;
  logic [4:0]  pin_cfg_high_r;
  logic        bg_req_r;
  logic [7:0]  result_high_r;
  logic [7:0]  result_low_r;
  logic [4:0]  tad_cnt_r;
  logic [1:0]  delay_cnt_r;
  logic        cal_pending_r;
  logic        tad_tick;
  logic        div_run;
  logic        wr_hit;
  logic        go_write;
  logic        flag_clear;
  logic        start_now;
  logic        done_evt;
  logic [12:0] cfg_all;
  logic [12:0] cfg_mask;
  logic [2:0]  clk_sel;
  logic [2:0]  acq_sel;

  // ==========================================================
  // helpers
  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    unique case (code)
      3'h0:    acq_tads = 5'd0;
      3'h1:    acq_tads = 5'd2;
      3'h2:    acq_tads = 5'd4;
      3'h3:    acq_tads = 5'd6;
      3'h4:    acq_tads = 5'd8;
      3'h5:    acq_tads = 5'd12;
      3'h6:    acq_tads = 5'd16;
      default: acq_tads = 5'd20;
    endcase
  endfunction : acq_tads

  function automatic logic wr_to(input logic [11:0] ofs);
    wr_to = wr_hit && wb_adr_i == ofs && wb_sel_i[0];
  endfunction : wr_to

  assign clk_sel  = config_r[BIT_CLK_HI:BIT_CLK_LO];
  assign acq_sel  = config_r[BIT_ACQ_HI:BIT_ACQ_LO];
  // write lands on the edge that sees ack high
  assign wr_hit   = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign done_evt = state_r == ST_CONV && cmp_done;
  assign div_run  = state_r == ST_ACQ || state_r == ST_CONV;

  // wr_to reads bus nets, so decode in always_comb
  always_comb begin
    go_write   = wr_to(OFS_CONV_CONTROL) && wb_dat_i[BIT_GO];
    flag_clear = wr_to(OFS_STATUS) && wb_dat_i[BIT_DONE_FLAG];
  end

  // small package drops pins 5-7 only
  assign cfg_mask = LARGE_PKG ? 13'h1FFF : 13'h1F1F;
  assign cfg_all  = {pin_cfg_high_r, pin_cfg_low_r} & cfg_mask;

  tad_divider #(
    .RC_DIV(RC_DIV)
  ) u_div (
    .clk     (clk),
    .nrst    (nrst),
    .run     (div_run),
    .clk_sel (clk_sel),
    .tad_tick(tad_tick)
  );

  // ==========================================================
  // wishbone slave
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      if (wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) begin
        unique case (wb_adr_i)
          OFS_PIN_CFG_LOW:  wb_dat_o[7:0] <= cfg_all[7:0];
          OFS_PIN_CFG_HIGH: wb_dat_o[7:0] <= {bg_req_r, 2'b00, cfg_all[12:8]};
          OFS_CONV_CONFIG:  wb_dat_o[7:0] <= config_r;
          OFS_CONV_CONTROL: wb_dat_o[7:0] <= control_r;
          OFS_RESULT_LOW:   wb_dat_o[7:0] <= result_low_r;
          OFS_RESULT_HIGH:  wb_dat_o[7:0] <= result_high_r;
          OFS_STATUS:       wb_dat_o[7:0] <= {7'h00, conversion_done_flag};
          default:          wb_dat_o[7:0] <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      pin_cfg_low_r <= RST_PIN_CFG;
    else if (wr_to(OFS_PIN_CFG_LOW))
      pin_cfg_low_r <= wb_dat_i[7:0];
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_cfg_high_r <= 5'h00;
      bg_req_r       <= 1'b0;
    end else if (wr_to(OFS_PIN_CFG_HIGH)) begin
      pin_cfg_high_r <= wb_dat_i[4:0];
      bg_req_r       <= wb_dat_i[BIT_BG_REQ];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      config_r <= RST_CONFIG;
    else if (wr_to(OFS_CONV_CONFIG))
      config_r <= wb_dat_i[7:0];
  end

  // ==========================================================
  // control register, go bit owned by sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control_r <= RST_CONTROL;
    end else begin
      if (wr_to(OFS_CONV_CONTROL)) begin
        control_r[7:2]    <= wb_dat_i[7:2];
        control_r[BIT_ON] <= wb_dat_i[BIT_ON];
      end
      if (go_write && wb_dat_i[BIT_ON] && state_r == ST_IDLE)
        control_r[BIT_GO] <= 1'b1;
      else if (done_evt || (wr_to(OFS_CONV_CONTROL) && !wb_dat_i[BIT_ON]))
        control_r[BIT_GO] <= 1'b0;
    end
  end

  // ==========================================================
  // conversion sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r     <= ST_IDLE;
      tad_cnt_r   <= 5'd0;
      delay_cnt_r <= 2'd0;
    // clearing converter_on aborts any conversion
    end else if (!control_r[BIT_ON]) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (control_r[BIT_GO]) begin
            delay_cnt_r <= 2'(INSTR_CYCLES - 1);
            tad_cnt_r   <= acq_tads(acq_sel);
            if (clk_sel == CLK_RC)
              state_r <= ST_DELAY;
            else if (acq_sel == 3'h0)
              state_r <= ST_CONV;
            else
              state_r <= ST_ACQ;
          end
        end
        ST_DELAY: begin
          if (delay_cnt_r == 2'd0)
            state_r <= acq_sel == 3'h0 ? ST_CONV : ST_ACQ;
          else
            delay_cnt_r <= delay_cnt_r - 2'd1;
        end
        ST_ACQ: begin
          if (tad_tick) begin
            if (tad_cnt_r <= 5'd1)
              state_r <= ST_CONV;
            else
              tad_cnt_r <= tad_cnt_r - 5'd1;
          end
        end
        ST_CONV: begin
          if (cmp_done)
            state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // calibration request, copied from the config cal bit outside conversion and held during it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      cal_pending_r <= 1'b0;
    else if (state_r != ST_CONV)
      cal_pending_r <= config_r[BIT_CAL];
  end

  // ==========================================================
  // result capture and done flag
  // results deliberately kept across reset
  always_ff @(posedge clk) begin
    if (done_evt) begin
      if (config_r[BIT_JUSTIFY]) begin
        result_high_r <= {6'h00, cmp_data[9:8]};
        result_low_r  <= cmp_data[7:0];
      end else begin
        result_high_r <= cmp_data[9:2];
        result_low_r  <= {cmp_data[1:0], 6'h00};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      conversion_done_flag <= 1'b0;
    else if (done_evt)
      conversion_done_flag <= 1'b1;
    else if (flag_clear)
      conversion_done_flag <= 1'b0;
  end

  // ==========================================================
  // conversion start decode, true on the edge entering conversion
  always_comb begin
    start_now = 1'b0;
    if (control_r[BIT_ON]) begin
      unique case (state_r)
        ST_IDLE:  start_now = control_r[BIT_GO] && clk_sel != CLK_RC && acq_sel == 3'h0;
        ST_DELAY: start_now = delay_cnt_r == 2'd0 && acq_sel == 3'h0;
        ST_ACQ:   start_now = tad_tick && tad_cnt_r <= 5'd1;
        ST_CONV:  start_now = 1'b0;
      endcase
    end
  end

  // ==========================================================
  // pin gating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_din_gated <= '0;
      pin_analog_en <= '0;
    end else begin
      pin_din_gated <= pin_din & cfg_all[NUM_PINS-1:0];
      pin_analog_en <= ~cfg_all[NUM_PINS-1:0] & cfg_mask[NUM_PINS-1:0];
    end
  end

  // ==========================================================
  // channel and reference selection
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      analog_mux_sel   <= 4'h0;
      neg_ref_ext      <= 1'b0;
      pos_ref_ext      <= 1'b0;
      converter_enable <= 1'b0;
    end else begin
      analog_mux_sel   <= control_r[BIT_CHS_HI:BIT_CHS_LO];
      neg_ref_ext      <= control_r[BIT_NEG_REF];
      pos_ref_ext      <= control_r[BIT_POS_REF];
      converter_enable <= control_r[BIT_ON];
    end
  end

  // ==========================================================
  // sampling and conversion strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample_en      <= 1'b0;
      conv_start     <= 1'b0;
      conv_calibrate <= 1'b0;
      conv_bit_clk   <= 1'b0;
    end else begin
      sample_en      <= control_r[BIT_ON] && state_r != ST_CONV;
      conv_start     <= start_now;
      conv_calibrate <= cal_pending_r && state_r == ST_CONV;
      conv_bit_clk   <= state_r == ST_CONV && tad_tick;
    end
  end

  // ==========================================================
  // band-gap power, shared with other requesters
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      bandgap_power <= 1'b0;
    else
      bandgap_power <= bg_req_r || bg_other_req;
  end

endmodule : adc_control_config
`default_nettype wire

// ===== tb/adc_control_config_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_config_checker #(
  parameter int NUM_PINS = 13
) (
  input wire logic                clk,
  input wire logic                nrst,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire logic                cmp_done,
  input wire logic                bg_other_req,
  input wire logic [NUM_PINS-1:0] pin_din,
  input wire logic [NUM_PINS-1:0] pin_din_gated,
  input wire logic [NUM_PINS-1:0] pin_analog_en,
  input wire logic                converter_enable,
  input wire logic                sample_en,
  input wire logic                conv_start,
  input wire logic                conv_bit_clk,
  input wire logic                bandgap_power,
  input wire logic                conversion_done_flag
);
  // ==========================================================
  // properties
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ack_next;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("bus request not answered next cycle");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
  property p_gate;
    ((pin_din_gated & pin_analog_en) == '0) && ((pin_din_gated & ~$past(pin_din)) == '0);
  endproperty
  a_gate: assert property (p_gate) else $error("analog pin digital input not zero");
  property p_off_quiet;
    !converter_enable |-> !sample_en && !conv_start;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("activity while converter off");
  property p_done_cause;
    $rose(conversion_done_flag) |-> $past(cmp_done);
  endproperty
  a_done_cause: assert property (p_done_cause) else $error("done flag set without completion");
  property p_done_sticky;
    conversion_done_flag && !wb_cyc_i |=> conversion_done_flag;
  endproperty
  a_done_sticky: assert property (p_done_sticky) else $error("done flag dropped without access");
  property p_start_pulse;
    conv_start |=> !conv_start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
  property p_bitclk_pulse;
    conv_bit_clk |=> !conv_bit_clk;
  endproperty
  a_bitclk_pulse: assert property (p_bitclk_pulse) else $error("bit clock pulse too long");
  property p_bg_rise;
    $rose(bg_other_req) |=> bandgap_power;
  endproperty
  a_bg_rise: assert property (p_bg_rise) else $error("band-gap not powered for requester");
  property p_reset_off;
    $rose(nrst) |-> !converter_enable && !conversion_done_flag;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("converter active after reset");
endmodule : adc_control_config_checker

bind adc_control_config adc_control_config_checker #(.NUM_PINS(NUM_PINS)) chk_u (
  .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .cmp_done(cmp_done), .bg_other_req(bg_other_req), .pin_din(pin_din), .pin_din_gated(pin_din_gated),
  .pin_analog_en(pin_analog_en), .converter_enable(converter_enable), .sample_en(sample_en),
  .conv_start(conv_start), .conv_bit_clk(conv_bit_clk), .bandgap_power(bandgap_power),
  .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// ===== tb/adc_control_config_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_control_config_tb;
  import adc_ctrl_pkg::*;
  logic        clk, nrst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cmp_done, bg_other_req;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i, analog_mux_sel;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [9:0]  cmp_data;
  logic [12:0] pin_din, pin_din_gated, pin_analog_en, pc;
  logic        neg_ref_ext, pos_ref_ext, converter_enable, sample_en, conv_start;
  logic        conv_calibrate, conv_bit_clk, bandgap_power, conversion_done_flag;
  logic [7:0]  ctl_m, hi_m, lo_m;
  int          errors, n_compared;
  int          divs[7] = '{2, 8, 32, RC_DIV_DEFAULT, 4, 16, 64};
  int          tads[8] = '{0, 2, 4, 6, 8, 12, 16, 20};

  adc_control_config dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .cmp_done(cmp_done), .cmp_data(cmp_data), .bg_other_req(bg_other_req),
    .pin_din(pin_din), .pin_din_gated(pin_din_gated), .pin_analog_en(pin_analog_en),
    .analog_mux_sel(analog_mux_sel), .neg_ref_ext(neg_ref_ext), .pos_ref_ext(pos_ref_ext),
    .converter_enable(converter_enable), .sample_en(sample_en), .conv_start(conv_start),
    .conv_calibrate(conv_calibrate), .conv_bit_clk(conv_bit_clk), .bandgap_power(bandgap_power),
    .conversion_done_flag(conversion_done_flag));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'h1;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk);
      t++;
    end while (wb_ack_o !== 1'b1);
    chk("ack_latency", 32'h2, 32'(t));
    q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(nm, 32'(e), 32'(q));
  endtask : rd

  task automatic convert(input int acq, input int cs, input logic just, input logic cal);
    int         t, exp_w;
    logic [9:0] d;
    exp_w = divs[cs] * tads[acq] + ((cs == 3) ? INSTR_CYCLES : 0);
    wr(OFS_CONV_CONFIG, {just, cal, 3'(acq), 3'(cs)});
    wr(OFS_CONV_CONTROL, {ctl_m[7:2], 2'b11});
    t = 0;
    while (conv_start !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    chk("acq_wait_min", 32'h1, 32'(t + divs[cs] > exp_w));
    chk("acq_wait_max", 32'h1, 32'(t <= exp_w + divs[cs] + 8));
    @(posedge clk);
    chk("calibrate", 32'(cal), 32'(conv_calibrate));
    chk("sampling_stopped", 32'h0, 32'(sample_en));
    rd(OFS_CONV_CONTROL, {ctl_m[7:2], 2'b11}, "busy");
    while (conv_bit_clk !== 1'b1) @(posedge clk);
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (conv_bit_clk !== 1'b1);
    chk("bit_time", 32'(divs[cs]), 32'(t));
    d = 10'($urandom);
    cmp_data <= d;
    cmp_done <= 1'b1;
    @(posedge clk);
    cmp_done <= 1'b0;
    t = 0;
    while (conversion_done_flag !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    hi_m = just ? {6'h00, d[9:8]} : d[9:2];
    lo_m = just ? d[7:0] : {d[1:0], 6'h00};
    rd(OFS_CONV_CONTROL, {ctl_m[7:2], 2'b01}, "idle");
    rd(OFS_RESULT_HIGH, hi_m, "result_high");
    rd(OFS_RESULT_LOW, lo_m, "result_low");
    rd(OFS_STATUS, 8'h01, "done_flag");
    wr(OFS_STATUS, 8'h01);
    rd(OFS_STATUS, 8'h00, "done_flag_clear");
  endtask : convert

  task automatic stop_test();
    if (errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test

  // ==========================================================
  // sequence
  initial begin
    {nrst, wb_cyc_i, wb_stb_i, wb_we_i, cmp_done, bg_other_req} = 6'h00;
    wb_adr_i = 12'h000;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    cmp_data = 10'h000;
    pin_din  = 13'h0000;
    errors = 0;
    n_compared = 0;
    void'($urandom(32'hF81DE2B9));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(OFS_PIN_CFG_LOW, RST_PIN_CFG, "pin_cfg_reset");
    rd(OFS_CONV_CONFIG, RST_CONFIG, "config_reset");
    rd(OFS_CONV_CONTROL, RST_CONTROL, "control_reset");
    chk("analog_en_reset", 32'h1FFF, 32'(pin_analog_en));
    rd(12'hF00, 8'h00, "unmapped");
    for (int c = 0; c < 16; c++) begin
      ctl_m = {2'($urandom), 4'(c), 2'b10};
      wr(OFS_CONV_CONTROL, ctl_m);
      ctl_m[1] = 1'b0;
      rd(OFS_CONV_CONTROL, ctl_m, "go_while_off");
      chk("mux_select", 32'(c), 32'(analog_mux_sel));
      chk("refs", 32'(ctl_m[7:6]), 32'({neg_ref_ext, pos_ref_ext}));
      chk("converter_off", 32'h0, 32'({converter_enable, sample_en}));
    end
    for (int k = 0; k < 4; k++) begin
      pc = 13'($urandom);
      pin_din <= 13'($urandom);
      bg_other_req <= k[1];
      wr(OFS_PIN_CFG_LOW, pc[7:0]);
      wr(OFS_PIN_CFG_HIGH, {k[0], 2'b00, pc[12:8]});
      rd(OFS_PIN_CFG_LOW, pc[7:0], "pin_cfg");
      chk("analog_en", {19'h00000, ~pc}, 32'(pin_analog_en));
      chk("din_gated", 32'(pin_din & pc), 32'(pin_din_gated));
      chk("bg_power", 32'(k != 0), 32'(bandgap_power));
    end
    ctl_m = 8'h01;
    wr(OFS_CONV_CONTROL, ctl_m);
    @(posedge clk);
    chk("converter_on", 32'h1, 32'(converter_enable));
    for (int i = 0; i < 8; i++) convert(i, i % 7, 1'(i), 1'(i == 5));
    wr(OFS_CONV_CONFIG, 8'h38);
    wr(OFS_CONV_CONTROL, 8'h03);
    repeat (10) @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(OFS_CONV_CONTROL, 8'h00, "control_after_reset");
    rd(OFS_RESULT_HIGH, hi_m, "result_high_kept");
    rd(OFS_RESULT_LOW, lo_m, "result_low_kept");
    stop_test();
  end

  initial begin
    #400000;
    errors++;
    stop_test();
  end
endmodule : adc_control_config_tb
`default_nettype wire
